// [rtl/access_gate.sv]
// gates bus decode events and master requests with the command enable bits
// assumes all event inputs come from logic on aclk; outputs are registered
`timescale 1ns/1ns
module access_gate (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [cmd_bits_pkg::CMD_W-1:0] cmd,
    input wire logic mem_access,
    input wire logic io_access,
    input wire logic palette_write,
    input wire logic [cmd_bits_pkg::SNOOP_W-1:0] palette_data,
    input wire logic special_cycle,
    input wire logic master_req,
    input wire logic master_wants_winv,
    output logic mem_claim,
    output logic io_claim,
    output logic snoop_capture,
    output logic [cmd_bits_pkg::SNOOP_W-1:0] snoop_data,
    output logic special_seen,
    output logic [cmd_bits_pkg::SPECIAL_CNT_W-1:0] special_count,
    output logic master_go,
    output logic use_winv
);
    typedef struct packed {
        logic mem_claim;
        logic io_claim;
        logic snoop_capture;
        logic [cmd_bits_pkg::SNOOP_W-1:0] snoop_data;
        logic special_seen;
        logic [cmd_bits_pkg::SPECIAL_CNT_W-1:0] special_count;
        logic master_go;
        logic use_winv;
    } gate_state_t;

    gate_state_t s;
    gate_state_t next_s;
    logic snooping;

    always_comb begin
        next_s = s;
        snooping = palette_write && cmd[cmd_bits_pkg::PALETTE_BIT];
        next_s.mem_claim = mem_access && cmd[cmd_bits_pkg::MEM_BIT];
        // palette writes decode like any i/o access unless snooped
        next_s.io_claim = (io_access || palette_write) && cmd[cmd_bits_pkg::IO_BIT] && !snooping;
        next_s.snoop_capture = snooping;
        if (snooping) begin
            next_s.snoop_data = palette_data;
        end
        next_s.special_seen = special_cycle && cmd[cmd_bits_pkg::SPECIAL_BIT];
        if (next_s.special_seen) begin
            next_s.special_count = s.special_count + 8'h01;
        end
        next_s.master_go = master_req && cmd[cmd_bits_pkg::MASTER_BIT];
        next_s.use_winv = next_s.master_go && master_wants_winv && cmd[cmd_bits_pkg::WINV_BIT];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign mem_claim = s.mem_claim;
    assign io_claim = s.io_claim;
    assign snoop_capture = s.snoop_capture;
    assign snoop_data = s.snoop_data;
    assign special_seen = s.special_seen;
    assign special_count = s.special_count;
    assign master_go = s.master_go;
    assign use_winv = s.use_winv;
endmodule // access_gate

// [rtl/cmd_bits_pkg.sv]
// constants for the pci command enable bits and their axi4-lite register map
// assumes a 32-bit axi4-lite bus with word-aligned registers
package cmd_bits_pkg;
    localparam int DATA_W = 32;
    localparam int CMD_W = 6;
    localparam logic [31:0] CMD_OFFSET = 32'h0000_0004;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0008;
    localparam int IO_BIT = 0;
    localparam int MEM_BIT = 1;
    localparam int MASTER_BIT = 2;
    localparam int SPECIAL_BIT = 3;
    localparam int WINV_BIT = 4;
    localparam int PALETTE_BIT = 5;
    localparam logic [CMD_W-1:0] CMD_RESET = 6'h00;
    localparam logic [CMD_W-1:0] CMD_WRITABLE = 6'h3f;
    localparam int SNOOP_W = 8;
    localparam int SNOOP_LSB = 0;
    localparam int SPECIAL_CNT_W = 8;
    localparam int SPECIAL_CNT_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/cmd_enable_regs.sv]
// axi4-lite slave holding the low pci command enable bits and a status word
// assumes decode and master request inputs are produced on aclk
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
// Behaviour
// - palette snoop on: do not claim palette writes, capture their data passively
// - write-invalidate enable 0 after reset: plain writes; 1 allows write-invalidate
// - write-invalidate enable bit is a writable control
// - special cycle control clear after reset: ignore every special cycle
// - special cycle control set: observe and act on special cycles
// - master enable resets 0; while 0 start no transactions; 1 allows mastering
// - memory decode enable resets 0; while 0 claim no memory accesses
// - i/o decode enable resets 0; while 0 claim no i/o accesses
// - palette snoop control bit is provided
// - palette snoop off: palette writes handled like any other access
module cmd_enable_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic mem_access,
    input wire logic io_access,
    input wire logic palette_write,
    input wire logic [7:0] palette_data,
    input wire logic special_cycle,
    input wire logic master_req,
    input wire logic master_wants_winv,
    output logic mem_claim,
    output logic io_claim,
    output logic snoop_capture,
    output logic special_seen,
    output logic master_go,
    output logic use_winv,
    output logic palette_snoop_en,
    output logic write_invalidate_en,
    output logic special_cycle_monitor_en,
    output logic master_en,
    output logic memory_decode_en,
    output logic io_decode_en
);
    localparam int IDX_W = ADDR_W - 2;
    localparam logic [IDX_W-1:0] CMD_IDX = cmd_bits_pkg::CMD_OFFSET[ADDR_W-1:2];
    localparam logic [IDX_W-1:0] STATUS_IDX = cmd_bits_pkg::STATUS_OFFSET[ADDR_W-1:2];

    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
        $error("address width must lie between 4 and 32");
    end

    typedef struct packed {
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] waddr;
        logic [7:0] wbyte;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [cmd_bits_pkg::CMD_W-1:0] cmd;
        logic last_cmd_wr;
    } regs_state_t;

    regs_state_t s;
    regs_state_t next_s;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic [IDX_W-1:0] wr_idx;
    logic [IDX_W-1:0] rd_idx;
    logic [cmd_bits_pkg::SNOOP_W-1:0] snoop_data;
    logic [cmd_bits_pkg::SPECIAL_CNT_W-1:0] special_count;

    assign awready = !s.aw_held && !s.bvalid;
    assign wready = !s.w_held && !s.bvalid;
    assign arready = !s.rvalid;
    assign aw_hs = awvalid && awready;
    assign w_hs = wvalid && wready;
    assign ar_hs = arvalid && arready;
    assign wr_idx = s.waddr[ADDR_W-1:2];
    assign rd_idx = araddr[ADDR_W-1:2];

    always_comb begin
        next_s = s;
        next_s.last_cmd_wr = 1'b0;
        if (aw_hs) begin
            next_s.aw_held = 1'b1;
            next_s.waddr = awaddr;
        end
        if (w_hs) begin
            next_s.w_held = 1'b1;
            next_s.wbyte = wdata[7:0];
            next_s.wlane0 = wstrb[0];
        end
        // address and data both in: perform the write, raise the response
        if (s.aw_held && s.w_held) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = cmd_bits_pkg::RESP_OKAY;
            if (wr_idx == CMD_IDX) begin
                if (s.wlane0) begin
                    next_s.cmd = s.wbyte[cmd_bits_pkg::CMD_W-1:0] & cmd_bits_pkg::CMD_WRITABLE;
                    next_s.last_cmd_wr = 1'b1;
                end
            end else if (wr_idx != STATUS_IDX) begin
                next_s.bresp = cmd_bits_pkg::RESP_SLVERR;
            end
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (ar_hs) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = cmd_bits_pkg::RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (rd_idx == CMD_IDX) begin
                next_s.rdata[cmd_bits_pkg::CMD_W-1:0] = s.cmd;
            end else if (rd_idx == STATUS_IDX) begin
                next_s.rdata[cmd_bits_pkg::SNOOP_LSB +: cmd_bits_pkg::SNOOP_W] = snoop_data;
                next_s.rdata[cmd_bits_pkg::SPECIAL_CNT_LSB +: cmd_bits_pkg::SPECIAL_CNT_W] = special_count;
            end else begin
                next_s.rresp = cmd_bits_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;
    assign io_decode_en = s.cmd[cmd_bits_pkg::IO_BIT];
    assign memory_decode_en = s.cmd[cmd_bits_pkg::MEM_BIT];
    assign master_en = s.cmd[cmd_bits_pkg::MASTER_BIT];
    assign special_cycle_monitor_en = s.cmd[cmd_bits_pkg::SPECIAL_BIT];
    assign write_invalidate_en = s.cmd[cmd_bits_pkg::WINV_BIT];
    assign palette_snoop_en = s.cmd[cmd_bits_pkg::PALETTE_BIT];

    access_gate u_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .cmd(s.cmd),
        .mem_access(mem_access),
        .io_access(io_access),
        .palette_write(palette_write),
        .palette_data(palette_data),
        .special_cycle(special_cycle),
        .master_req(master_req),
        .master_wants_winv(master_wants_winv),
        .mem_claim(mem_claim),
        .io_claim(io_claim),
        .snoop_capture(snoop_capture),
        .snoop_data(snoop_data),
        .special_seen(special_seen),
        .special_count(special_count),
        .master_go(master_go),
        .use_winv(use_winv)
    );

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_palette_snooped: assert property (
        palette_write && palette_snoop_en |=> !io_claim && snoop_capture
    ) else $error("snooped palette write was claimed or not captured");

    chk_winv_gated: assert property (
        use_winv |-> $past(write_invalidate_en) && $past(master_en) && master_go
    ) else $error("write-invalidate used while disabled");

    chk_winv_writable: assert property (
        s.last_cmd_wr |-> bvalid && write_invalidate_en == s.wbyte[cmd_bits_pkg::WINV_BIT]
    ) else $error("write-invalidate enable did not take the written value");

    chk_special_ignored: assert property (
        !special_cycle_monitor_en |=> !special_seen && $stable(special_count)
    ) else $error("special cycle acted on while monitoring off");

    chk_special_seen: assert property (
        special_cycle && special_cycle_monitor_en |=> special_seen ##0 special_count == $past(special_count) + 8'h01
    ) else $error("special cycle not observed while monitoring on");

    chk_master_gated: assert property (
        !master_en [*2] |-> !master_go && !use_winv
    ) else $error("transaction started without master enable");

    chk_mem_decode: assert property (
        mem_access |=> mem_claim == $past(memory_decode_en)
    ) else $error("memory claim disagrees with decode enable");

    chk_io_decode: assert property (
        !io_decode_en |=> !io_claim
    ) else $error("i/o access claimed while decode disabled");

    chk_palette_plain: assert property (
        palette_write && !palette_snoop_en |=> io_claim == $past(io_decode_en) && !snoop_capture
    ) else $error("unsnooped palette write not handled as plain access");

    chk_cmd_readback: assert property (
        ar_hs && rd_idx == CMD_IDX |=> rvalid && rdata == {26'h0, $past(s.cmd)}
    ) else $error("command read did not return the enable bits");
endmodule // cmd_enable_regs

// [tb/pci_agent_model.sv]
// bus agents raising decode events and master requests as one-cycle pulses
// assumes fire and pd are driven on aclk by the bench
`timescale 1ns/1ns
module pci_agent_model (
    input wire logic aclk,
    input wire logic [5:0] fire,
    input wire logic [7:0] pd,
    output logic mem_access,
    output logic io_access,
    output logic palette_write,
    output logic special_cycle,
    output logic master_req,
    output logic master_wants_winv,
    output logic [7:0] palette_data
);
    logic [7:0] data_line = 8'h00;
    assign palette_data = data_line;
    always @(posedge aclk) begin
        // master asks for write-invalidate only as commanded
        {mem_access, io_access, palette_write, special_cycle, master_req, master_wants_winv} <= fire;
        // released data line toggles instead of holding
        data_line <= fire[3] ? pd : ~data_line;
    end
endmodule // pci_agent_model

// [tb/test_pci_command_enable_bits.sv]
// self-checking bench for the command enable bits over axi4-lite
// assumes cmd_bits_pkg is compiled first
`timescale 1ns/1ns
module test_pci_command_enable_bits;
    localparam logic [7:0] CMD_A = 8'(cmd_bits_pkg::CMD_OFFSET);
    localparam logic [7:0] ST_A = 8'(cmd_bits_pkg::STATUS_OFFSET);
    localparam logic [1:0] OK = cmd_bits_pkg::RESP_OKAY;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] fire = 6'h00;
    logic [7:0] pd = 8'h00;
    logic mem_access, io_access, palette_write, special_cycle, master_req, master_wants_winv;
    logic [7:0] palette_data;
    logic mem_claim, io_claim, snoop_capture, special_seen, master_go, use_winv;
    logic palette_snoop_en, write_invalidate_en, special_cycle_monitor_en, master_en, memory_decode_en, io_decode_en;
    logic [5:0] cmd = 6'h00;
    logic [7:0] last_pd = 8'h00;
    logic [7:0] n_spec = 8'h00;
    logic [5:0] tbl [0:8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h14, 6'h20, 6'h21, 6'h3f};
    wire [5:0] outs = {mem_claim, io_claim, snoop_capture, special_seen, master_go, use_winv};
    wire [5:0] en = {palette_snoop_en, write_invalidate_en, special_cycle_monitor_en, master_en, memory_decode_en,
        io_decode_en};
    int failures = 0;
    int n_checks = 0;

    always #5 aclk = ~aclk;

    pci_agent_model agents (.aclk, .fire, .pd, .mem_access, .io_access, .palette_write, .special_cycle, .master_req,
        .master_wants_winv, .palette_data);
    cmd_enable_regs dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .mem_access, .io_access, .palette_write, .palette_data, .special_cycle, .master_req,
        .master_wants_winv, .mem_claim, .io_claim, .snoop_capture, .special_seen, .master_go, .use_winv,
        .palette_snoop_en, .write_invalidate_en, .special_cycle_monitor_en, .master_en, .memory_decode_en,
        .io_decode_en);

    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int k;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        bready <= 1'h0;
        if (k == 40) failures++;
        if (k == 40) complete_run();
        chk(32'(bresp), 32'(er));
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int k;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rready <= 1'h0;
        if (k == 40) failures++;
        if (k == 40) complete_run();
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
        @(posedge aclk);
    endtask

    // one event burst through the agents, then the gated pulse and its end
    task automatic ev(input logic [5:0] b);
        fire <= b;
        pd <= pd + 8'h35;
        @(posedge aclk);
        fire <= 6'h00;
        repeat (2) @(posedge aclk);
        chk(32'(outs), 32'({b[5] & cmd[1], cmd[0] & (b[4] | b[3] & !cmd[5]), b[3] & cmd[5], b[2] & cmd[3],
            b[1] & cmd[2], b[1] & b[0] & cmd[2] & cmd[4]}));
        if (b[3] & cmd[5]) last_pd = pd;
        if (b[2] & cmd[3]) n_spec++;
        @(posedge aclk);
        chk(32'(outs), 32'h0);
    endtask

    task automatic reset_vals();
        rd(CMD_A, 32'h0, OK);
        chk(32'(en), 32'h0);
        ev(6'h37);
        ev(6'h08);
    endtask

    task automatic bit_table();
        for (int i = 0; i < 9; i++) begin
            wr(CMD_A, {26'h3ff_ffff, tbl[i]}, 4'h1, OK);
            cmd = tbl[i];
            rd(CMD_A, 32'(cmd), OK);
            chk(32'(en), 32'(cmd));
            ev(6'h27);
            ev(6'h10);
            ev(6'h08);
        end
        rd(ST_A, {16'h0, n_spec, last_pd}, OK);
    endtask

    task automatic bad_access();
        wr(CMD_A, 32'h0000_0000, 4'he, OK);
        rd(CMD_A, 32'(cmd), OK);
        wr(8'h10, 32'h0000_0000, 4'hf, cmd_bits_pkg::RESP_SLVERR);
        rd(8'h10, 32'h0, cmd_bits_pkg::RESP_SLVERR);
        wr(ST_A, 32'hffff_ffff, 4'hf, OK);
        rd(ST_A, {16'h0, n_spec, last_pd}, OK);
        rd(CMD_A, 32'(cmd), OK);
    endtask

    // reset from a fully enabled state clears every bit again
    task automatic mid_reset();
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        cmd = 6'h00;
        n_spec = 8'h00;
        last_pd = 8'h00;
        reset_vals();
        rd(ST_A, 32'h0, OK);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        reset_vals();
        bit_table();
        bad_access();
        mid_reset();
        complete_run();
    end
endmodule // test_pci_command_enable_bits
